/* File: pkg/fifo_status_map.svh */
// field positions, widths and reset values of the per-FIFO status register
`ifndef FIFO_STATUS_MAP_SVH
`define FIFO_STATUS_MAP_SVH

`define FSTA_WORD_W        32
`define FSTA_IDX_W         5
`define FSTA_IDX_LSB       8
`define FSTA_IDX_MSB       12
`define FSTA_ABORTED_BIT   7
`define FSTA_LOST_ARB_BIT  6
`define FSTA_BUS_ERR_BIT   5
`define FSTA_ATTEMPTS_BIT  4
`define FSTA_OVERFLOW_BIT  3
`define FSTA_EMPTY_FULL_BIT 2
`define FSTA_HALF_BIT      1
`define FSTA_NF_NE_BIT     0
`define FSTA_COUNT_W       6
`define FSTA_NUM_FIFOS     31
`define FSTA_RESET_WORD    32'h0000_0000
`define FSTA_IDX_RESET     5'h00
`define FSTA_COUNT_RESET   6'h00

`endif

/* File: pkg/fifo_status_pkg.sv */
// types shared by the per-FIFO status register block
`default_nettype none
`include "fifo_status_map.svh"

package fifo_status_pkg;

	// static configuration of one FIFO, from its control register
	typedef struct packed {
		logic                     fifo_direction_select; // 1 = transmit
		logic [`FSTA_IDX_W-1:0]   fifo_depth_setting;    // depth minus one
	} fifo_cfg_t;

	// single-cycle events reported by the FIFO engine, one set per FIFO
	typedef struct packed {
		logic tx_request;       // software set the transmit request
		logic fifo_reset;       // FIFO reset: pointers and flags to zero
		logic tx_done;          // a transmit completed or aborted
		logic tx_aborted;       // qualifies tx_done
		logic tx_lost_arb;      // qualifies tx_done
		logic tx_bus_err;       // qualifies tx_done
		logic tx_attempts_out;  // retransmit attempts exhausted
		logic rx_overflow;      // receive message dropped, FIFO full
		logic push;             // one message enters the FIFO
		logic pop;              // one message leaves the FIFO
	} fifo_event_t;

	// sticky flags of one FIFO
	typedef struct packed {
		logic tx_aborted_status;
		logic tx_lost_arbitration_status;
		logic tx_bus_error_status;
		logic tx_attempts_exhausted_flag;
		logic rx_overflow_flag;
	} fifo_flags_t;

	// live state of one FIFO
	typedef struct packed {
		fifo_flags_t                 flags;
		logic [`FSTA_IDX_W-1:0]     head;  // next slot to fill
		logic [`FSTA_IDX_W-1:0]     tail;  // next message to leave
		logic [`FSTA_COUNT_W-1:0]   count; // messages held
		logic [`FSTA_WORD_W-1:0]    word;  // status word as read
	} fifo_state_t;

endpackage : fifo_status_pkg

`default_nettype wire

/* File: rtl/can_fifo_status_reg.sv */
// per-FIFO status registers of the CAN FD controller, one per FIFO
//
// How it works
// - bits 31 to 13 read zero, no storage
// - transmit FIFO: index of next message to send
// - receive FIFO: index of next slot to fill
// - index counts zero up to depth minus one
// - bit 7: message was aborted
// - bit 6: message lost arbitration
// - bit 5: bus error during transmission
// - bit 4: transmit attempts exhausted pending
// - receive FIFO: attempts flag reads zero
// - transmit request or zero write clears status
// - bits 7-3 hardware set, software clear; reset zero
// - status bits set only at completion; cleared by request, zero write or reset
// - bit 3: receive overflow; zero for transmit
// - bits 2 and 0 follow FIFO occupancy
`timescale 1ns/1ps
`include "fifo_status_map.svh"
`default_nettype none

module can_fifo_status_reg
#(
	parameter int NUM_FIFOS = `FSTA_NUM_FIFOS
)
(
	input  wire logic                                  SYS_CLK,
	input  wire logic                                  SYS_RST,
	input  wire fifo_status_pkg::fifo_cfg_t [NUM_FIFOS-1:0]   CFG,
	input  wire fifo_status_pkg::fifo_event_t [NUM_FIFOS-1:0] EVENTS,
	input  wire logic [NUM_FIFOS-1:0]                 REG_WR,
	input  wire logic [`FSTA_WORD_W-1:0]              REG_WR_DATA,
	output logic [NUM_FIFOS-1:0][`FSTA_WORD_W-1:0]    REG_RD_DATA
);

	// whole state of the block: one record per FIFO
	typedef struct packed {
		fifo_status_pkg::fifo_state_t [NUM_FIFOS-1:0] fifo;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	// advance a slot pointer, wrapping at the configured depth
	function automatic logic [`FSTA_IDX_W-1:0] wrap_inc
	(
		input logic [`FSTA_IDX_W-1:0] ptr,
		input logic [`FSTA_IDX_W-1:0] last
	);
		logic [`FSTA_IDX_W-1:0] res;
		res = (ptr >= last) ? `FSTA_IDX_RESET : ptr + 5'h01;
		return res;
	endfunction : wrap_inc

	// assemble the word software reads from the next state
	function automatic logic [`FSTA_WORD_W-1:0] build_word
	(
		input fifo_status_pkg::fifo_state_t st,
		input fifo_status_pkg::fifo_cfg_t   cfg
	);
		logic [`FSTA_WORD_W-1:0]  w;
		logic [`FSTA_COUNT_W-1:0] depth;
		logic                     is_tx;
		logic                     empty;
		logic                     full;
		w     = `FSTA_RESET_WORD;
		depth = {1'b0, cfg.fifo_depth_setting} + 6'h01;
		is_tx = cfg.fifo_direction_select;
		empty = (st.count == `FSTA_COUNT_RESET);
		full  = (st.count >= depth);
		// index: send side for transmit, fill side for receive
		if (is_tx)
		begin
			w[`FSTA_IDX_MSB:`FSTA_IDX_LSB] = st.tail;
		end
		else
		begin
			w[`FSTA_IDX_MSB:`FSTA_IDX_LSB] = st.head;
		end
		w[`FSTA_ABORTED_BIT]  = st.flags.tx_aborted_status;
		w[`FSTA_LOST_ARB_BIT] = st.flags.tx_lost_arbitration_status;
		w[`FSTA_BUS_ERR_BIT]  = st.flags.tx_bus_error_status;
		w[`FSTA_ATTEMPTS_BIT] = is_tx & st.flags.tx_attempts_exhausted_flag;
		w[`FSTA_OVERFLOW_BIT] = ~is_tx & st.flags.rx_overflow_flag;
		// occupancy flags swap meaning with direction
		if (is_tx)
		begin
			w[`FSTA_EMPTY_FULL_BIT] = empty;
			w[`FSTA_HALF_BIT]       = ({st.count, 1'b0} <= {1'b0, depth});
			w[`FSTA_NF_NE_BIT]      = ~full;
		end
		else
		begin
			w[`FSTA_EMPTY_FULL_BIT] = full;
			w[`FSTA_HALF_BIT]       = ({st.count, 1'b0} >= {1'b0, depth});
			w[`FSTA_NF_NE_BIT]      = ~empty;
		end
		return w;
	endfunction : build_word

	// next state: every FIFO handled alone, no shared state between them
	always_comb
	begin
		fifo_status_pkg::fifo_state_t st;
		fifo_status_pkg::fifo_event_t ev;
		fifo_status_pkg::fifo_cfg_t   cfg;
		logic [`FSTA_IDX_W-1:0]       last;
		logic                         wr;
		logic                         do_push;
		logic                         do_pop;
		st        = '0;
		ev        = '0;
		cfg       = '0;
		last      = `FSTA_IDX_RESET;
		wr        = 1'b0;
		do_push   = 1'b0;
		do_pop    = 1'b0;
		state_nxt = state_r;
		for (int i = 0; i < NUM_FIFOS; i++)
		begin
			st   = state_r.fifo[i];
			ev   = EVENTS[i];
			cfg  = CFG[i];
			last = cfg.fifo_depth_setting;
			wr   = REG_WR[i];
			// guard the pointers: no push when full, no pop when empty
			do_push = ev.push &
				(st.count <= {1'b0, last});
			do_pop  = ev.pop & (st.count != `FSTA_COUNT_RESET);
			if (ev.fifo_reset)
			begin
				// a FIFO reset wipes pointers and flags together
				st = '0;
			end
			else
			begin
				// clears first: transmit request, then zero writes
				if (ev.tx_request)
				begin
					st.flags.tx_aborted_status          = 1'b0;
					st.flags.tx_lost_arbitration_status = 1'b0;
					st.flags.tx_bus_error_status        = 1'b0;
				end
				if (wr)
				begin
					// a one written leaves a flag alone; a zero clears it
					st.flags.tx_aborted_status =
						st.flags.tx_aborted_status &
						REG_WR_DATA[`FSTA_ABORTED_BIT];
					st.flags.tx_lost_arbitration_status =
						st.flags.tx_lost_arbitration_status &
						REG_WR_DATA[`FSTA_LOST_ARB_BIT];
					st.flags.tx_bus_error_status =
						st.flags.tx_bus_error_status &
						REG_WR_DATA[`FSTA_BUS_ERR_BIT];
					st.flags.tx_attempts_exhausted_flag =
						st.flags.tx_attempts_exhausted_flag &
						REG_WR_DATA[`FSTA_ATTEMPTS_BIT];
					st.flags.rx_overflow_flag =
						st.flags.rx_overflow_flag &
						REG_WR_DATA[`FSTA_OVERFLOW_BIT];
				end
				// sets come last so an event in the clearing cycle survives
				if (ev.tx_done & cfg.fifo_direction_select)
				begin
					if (ev.tx_aborted)
					begin
						st.flags.tx_aborted_status = 1'b1;
					end
					if (ev.tx_lost_arb)
					begin
						st.flags.tx_lost_arbitration_status = 1'b1;
					end
					if (ev.tx_bus_err)
					begin
						st.flags.tx_bus_error_status = 1'b1;
					end
				end
				if (ev.tx_attempts_out & cfg.fifo_direction_select)
				begin
					st.flags.tx_attempts_exhausted_flag = 1'b1;
				end
				if (ev.rx_overflow & ~cfg.fifo_direction_select)
				begin
					st.flags.rx_overflow_flag = 1'b1;
				end
				// occupancy and the two slot pointers
				if (do_push)
				begin
					st.head = wrap_inc(st.head, last);
				end
				if (do_pop)
				begin
					st.tail = wrap_inc(st.tail, last);
				end
				if (do_push & ~do_pop)
				begin
					st.count = st.count + 6'h01;
				end
				else if (do_pop & ~do_push)
				begin
					st.count = st.count - 6'h01;
				end
			end
			// word is registered so the read port comes from flops;
			// it is built from the next state, so it adds no latency after an event
			st.word = build_word(st, cfg);
			state_nxt.fifo[i] = st;
		end
	end

	// the one state register; synchronous reset clears every flag
	always_ff @(posedge SYS_CLK)
	begin
		if (SYS_RST)
		begin
			state_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// read port: each FIFO's word straight from its register
	always_comb
	begin
		for (int i = 0; i < NUM_FIFOS; i++)
		begin
			REG_RD_DATA[i] = state_r.fifo[i].word;
		end
	end

endmodule : can_fifo_status_reg

`default_nettype wire

/* File: testbench/fsta_props.sv */
// concurrent checks on the per-FIFO status words
`timescale 1ns/1ps
`include "fifo_status_map.svh"
`default_nettype none
module fsta_props
#(
	parameter int NUM_FIFOS = 2
)
(
	input wire logic                                      SYS_CLK,
	input wire logic                                      SYS_RST,
	input wire fifo_status_pkg::fifo_cfg_t [NUM_FIFOS-1:0]   CFG,
	input wire fifo_status_pkg::fifo_event_t [NUM_FIFOS-1:0] EVENTS,
	input wire logic [NUM_FIFOS-1:0]                      REG_WR,
	input wire logic [`FSTA_WORD_W-1:0]                   REG_WR_DATA,
	input wire logic [NUM_FIFOS-1:0][`FSTA_WORD_W-1:0]    REG_RD_DATA
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	// fifo 0 is the transmit one, fifo 1 receives
	logic [4:0] idx0;
	logic [4:0] nxt0;
	assign idx0 = REG_RD_DATA[0][12:8];
	assign nxt0 = (idx0 == CFG[0].fifo_depth_setting) ? 5'h00 : idx0 + 5'h01;
	// a finished send reporting an abort
	sequence abort_done;
		EVENTS[0].tx_done && EVENTS[0].tx_aborted && !EVENTS[0].fifo_reset;
	endsequence
	upper_zero_a: assert property (
		REG_RD_DATA[0][31:13] == 19'h0 && REG_RD_DATA[1][31:13] == 19'h0)
		else $error("upper bits not zero");
	abort_sets_a: assert property (
		abort_done |=> REG_RD_DATA[0][7]) else $error("abort not set");
	req_clear_a: assert property (
		EVENTS[0].tx_request && !EVENTS[0].tx_done && !EVENTS[0].fifo_reset
		|=> REG_RD_DATA[0][7:5] == 3'h0) else $error("request kept status");
	zero_write_a: assert property (
		REG_WR[0] && !REG_WR_DATA[4] && !EVENTS[0].tx_attempts_out
		|=> !REG_RD_DATA[0][4]) else $error("zero write kept flag");
	status_hold_a: assert property (
		!EVENTS[0].tx_done && !EVENTS[0].tx_request && !REG_WR[0]
		&& !EVENTS[0].fifo_reset |=> $stable(REG_RD_DATA[0][7:5]))
		else $error("status moved");
	dir_zero_a: assert property (
		!REG_RD_DATA[0][3] && !REG_RD_DATA[1][4]) else $error("flag on wrong side");
	rx_overflow_a: assert property (
		EVENTS[1].rx_overflow && !EVENTS[1].fifo_reset |=> REG_RD_DATA[1][3])
		else $error("overflow not set");
	index_step_a: assert property (
		EVENTS[0].pop && !REG_RD_DATA[0][2] && !EVENTS[0].fifo_reset
		|=> idx0 == $past(nxt0)) else $error("index did not step");
	// a finished send that lost arbitration, or that met a bus error
	sequence lost_done;
		EVENTS[0].tx_done && EVENTS[0].tx_lost_arb && !EVENTS[0].fifo_reset;
	endsequence
	sequence err_done;
		EVENTS[0].tx_done && EVENTS[0].tx_bus_err && !EVENTS[0].fifo_reset;
	endsequence
	lost_sets_a: assert property (
		lost_done |=> REG_RD_DATA[0][6]) else $error("lost arb not set");
	err_sets_a: assert property (
		err_done |=> REG_RD_DATA[0][5]) else $error("bus error not set");
	attempts_set_a: assert property (
		EVENTS[0].tx_attempts_out && !EVENTS[0].fifo_reset
		|=> REG_RD_DATA[0][4]) else $error("attempts flag not set");
	// a wiped transmit FIFO reads empty, index zero, no flags
	reset_empty_a: assert property (
		EVENTS[0].fifo_reset |=> REG_RD_DATA[0][12:0] == 13'h0007)
		else $error("fifo reset not empty");
endmodule : fsta_props
bind can_fifo_status_reg fsta_props #(.NUM_FIFOS(NUM_FIFOS)) props (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CFG(CFG), .EVENTS(EVENTS),
	.REG_WR(REG_WR), .REG_WR_DATA(REG_WR_DATA), .REG_RD_DATA(REG_RD_DATA));
`default_nettype wire

/* File: testbench/fsta_host.sv */
// host software model: status writes and reads
`timescale 1ns/1ps
`include "fifo_status_map.svh"
`default_nettype none
module fsta_host
#(
	parameter int NUM_FIFOS = 2
)
(
	input  wire logic                                   SYS_CLK,
	input  wire logic [NUM_FIFOS-1:0][`FSTA_WORD_W-1:0] REG_RD_DATA,
	output var logic [NUM_FIFOS-1:0]                    REG_WR,
	output var logic [`FSTA_WORD_W-1:0]                 REG_WR_DATA
);
	// idle data is junk so a stale sample cannot pass for a write
	initial
	begin
		REG_WR = '0;
		REG_WR_DATA = 32'hA5A5_A5A5;
	end
	// one-cycle strobe; zero in bits 7..3 clears, one leaves
	task wr(input int f, input logic [`FSTA_WORD_W-1:0] d);
		@(negedge SYS_CLK);
		REG_WR[f] = 1'b1;
		REG_WR_DATA = d;
		@(negedge SYS_CLK);
		REG_WR[f] = 1'b0;
		REG_WR_DATA = ~d;
	endtask : wr
	task rd(input int f, output logic [`FSTA_WORD_W-1:0] d);
		d = REG_RD_DATA[f];
	endtask : rd
endmodule : fsta_host
`default_nettype wire

/* File: testbench/can_fifo_status_reg_bench.sv */
// self-checking bench for the per-FIFO status registers
`timescale 1ns/1ps
`include "fifo_status_map.svh"
`default_nettype none
`define CHK(w, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %h got %h", w, e, g); end end
module can_fifo_status_reg_bench;
	logic                               SYS_CLK = 1'b0;
	logic                               SYS_RST = 1'b1;
	fifo_status_pkg::fifo_cfg_t [1:0]   CFG;
	fifo_status_pkg::fifo_event_t [1:0] EVENTS = '0;
	logic [1:0]                         REG_WR;
	logic [`FSTA_WORD_W-1:0]            REG_WR_DATA;
	logic [1:0][`FSTA_WORD_W-1:0]       REG_RD_DATA;
	int                                 fails = 0;
	int                                 check_count = 0;
	int                                 cyc = 0;
	can_fifo_status_reg #(.NUM_FIFOS(2)) dut (.SYS_CLK(SYS_CLK),
		.SYS_RST(SYS_RST), .CFG(CFG), .EVENTS(EVENTS), .REG_WR(REG_WR),
		.REG_WR_DATA(REG_WR_DATA), .REG_RD_DATA(REG_RD_DATA));
	fsta_host #(.NUM_FIFOS(2)) host (.SYS_CLK(SYS_CLK),
		.REG_RD_DATA(REG_RD_DATA), .REG_WR(REG_WR),
		.REG_WR_DATA(REG_WR_DATA));
	always #50 SYS_CLK = ~SYS_CLK;
	// one-cycle event pulse, driven on the falling edge
	task ev(input int f, input logic [9:0] e);
		@(negedge SYS_CLK);
		EVENTS[f] = e;
		@(negedge SYS_CLK);
		EVENTS[f] = '0;
	endtask : ev
	task see(input int f, input logic [`FSTA_WORD_W-1:0] e);
		logic [`FSTA_WORD_W-1:0] d;
		host.rd(f, d);
		`CHK("status word", e, d)
	endtask : see
	task close_out;
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// a hang is cut off well past the few dozen cycles needed
	always @(posedge SYS_CLK)
	begin
		cyc++;
		if (cyc == 400)
		begin
			fails++;
			close_out;
		end
	end
	initial
	begin
		CFG = {6'h01, 6'h23}; // fifo 1 rx depth 2, fifo 0 tx depth 4
		repeat (3) @(negedge SYS_CLK);
		SYS_RST = 1'b0;
		@(negedge SYS_CLK); // occupancy bits settle one edge later
		see(0, 32'h7);
		see(1, 32'h0);
		// four pushes fill the transmit FIFO, the fifth is refused
		for (int i = 0; i < 5; i++) ev(0, 10'h002);
		see(0, 32'h0);
		// done with abort, lost and error, plus one pop
		ev(0, 10'h0F1);
		see(0, 32'h1E1);
		ev(0, 10'h008);
		see(0, 32'h1F1);
		ev(0, 10'h200);
		see(0, 32'h111);
		host.wr(0, 32'hFFFF_FFEF);
		see(0, 32'h101);
		for (int i = 0; i < 3; i++) ev(0, 10'h001);
		see(0, 32'h7);
		ev(1, 10'h002);
		see(1, 32'h103);
		// push with transmit events on a receiver: only the push counts
		ev(1, 10'h08A);
		see(1, 32'h7);
		ev(1, 10'h004);
		see(1, 32'hF);
		// overflow event on a transmitter is ignored
		ev(0, 10'h0C6);
		see(0, 32'h83);
		ev(0, 10'h100);
		@(negedge SYS_CLK);
		see(0, 32'h7);
		see(1, 32'hF);
		ev(0, 10'h0A0);
		see(0, 32'h47);
		ev(0, 10'h090);
		see(0, 32'h67);
		// a zero write and a new abort in one cycle: the set wins
		fork
			host.wr(0, 32'h0000_0000);
			ev(0, 10'h0C0);
		join
		see(0, 32'h87);
		// transmit request with a lost-arbitration finish: set wins
		ev(0, 10'h2A0);
		see(0, 32'h47);
		ev(1, 10'h001);
		see(1, 32'hB);
		// push and pop together: pointers move, count stays
		ev(1, 10'h003);
		see(1, 32'h10B);
		host.wr(1, 32'h0000_0000);
		see(1, 32'h103);
		close_out;
	end
endmodule : can_fifo_status_reg_bench
`default_nettype wire
